// ===== hdl/sarx_slot_map.sv
// secondary audio serial port receive slot map and routing, channels 3 to 5
//
// Operation
// - channel 3 and 4 bits 7:6 read zero; writes there are dropped.
// - channel 5 bit 7 reads zero; writes there are dropped.
// - channel 3 bit 5 zero disables, one routes slot to DAC channel 3.
// - five-bit slot field selects TDM slot, or left/right slot 0-15 otherwise.
// - channel 3 register at 0x2a, resets to 0x02.
// - channel 4 bit 5 zero disables, one routes slot to DAC channel 4.
// - channel 4 register at 0x2b, resets to 0x03, same slot encoding.
// - channel 5 bits 6:5 pick off, DAC 5, ADC 1 loopback, reserved.
// - channel 5 register at 0x2c, resets to 0x04, same slot encoding.
`timescale 1ns/1ps
`include "sarx_params.svh"

module sarx_slot_map
(
  input  wire logic               i_mclk,
  input  wire logic               i_rst,
  input  wire logic [7:0]         i_reg_addr,
  input  wire logic               i_reg_wr,
  input  wire sarx_pkg::sarx_reg_t i_reg_wdata,
  input  wire logic               i_reg_rd,
  output      sarx_pkg::sarx_reg_t o_reg_rdata,
  input  wire logic               i_fmt_tdm,
  input  wire logic               i_slot_valid,
  input  wire sarx_pkg::sarx_slot_t i_slot_num,
  input  wire logic               i_slot_right,
  input  wire sarx_pkg::sarx_data_t i_slot_data,
  output      sarx_pkg::sarx_data_t o_dac3_data,
  output      logic               o_dac3_valid,
  output      sarx_pkg::sarx_data_t o_dac4_data,
  output      logic               o_dac4_valid,
  output      sarx_pkg::sarx_data_t o_dac5_data,
  output      logic               o_dac5_valid,
  output      sarx_pkg::sarx_data_t o_adc1_lb_data,
  output      logic               o_adc1_lb_valid
);
  import sarx_pkg::*;

  sarx_reg_t    sec_rx_ch3_route_sel;
  sarx_reg_t    sec_rx_ch4_route_sel;
  sarx_reg_t    sec_rx_ch5_route_sel;
  sarx_slot_t   sec_rx_ch3_slot_index;
  sarx_slot_t   sec_rx_ch4_slot_index;
  sarx_slot_t   sec_rx_ch5_slot_index;
  sarx_route5_e ch5_route;
  logic         ch3_en;
  logic         ch4_en;
  logic         hit3;
  logic         hit4;
  logic         hit5;

  // true when the incoming slot is the one a channel's slot field selects
  function automatic logic slot_hit(input logic tdm, input sarx_slot_t num,
                                    input logic right, input sarx_slot_t sel);
    if (tdm)
      slot_hit = (num == sel);
    else
      slot_hit = (num[`SARX_SLOT_MSB] == 1'b0) && (right == sel[`SARX_SIDE_BIT]) &&
                 (num[`SARX_SLOT_MSB-1:0] == sel[`SARX_SLOT_MSB-1:0]);
  endfunction

  assign sec_rx_ch3_slot_index = sec_rx_ch3_route_sel[`SARX_SLOT_MSB:0];
  assign sec_rx_ch4_slot_index = sec_rx_ch4_route_sel[`SARX_SLOT_MSB:0];
  assign sec_rx_ch5_slot_index = sec_rx_ch5_route_sel[`SARX_SLOT_MSB:0];
  assign ch3_en    = sec_rx_ch3_route_sel[`SARX_EN_BIT];
  assign ch4_en    = sec_rx_ch4_route_sel[`SARX_EN_BIT];
  assign ch5_route = sarx_route5_e'(sec_rx_ch5_route_sel[`SARX_ROUTE_MSB:`SARX_ROUTE_LSB]);

  assign hit3 = i_slot_valid && slot_hit(i_fmt_tdm, i_slot_num, i_slot_right,
                                         sec_rx_ch3_slot_index);
  assign hit4 = i_slot_valid && slot_hit(i_fmt_tdm, i_slot_num, i_slot_right,
                                         sec_rx_ch4_slot_index);
  assign hit5 = i_slot_valid && slot_hit(i_fmt_tdm, i_slot_num, i_slot_right,
                                         sec_rx_ch5_slot_index);

  // register writes; reserved bits are masked so they stay zero
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      sec_rx_ch3_route_sel <= `SARX_RST_CH3;
      sec_rx_ch4_route_sel <= `SARX_RST_CH4;
      sec_rx_ch5_route_sel <= `SARX_RST_CH5;
    end
    else if (i_reg_wr)
    begin
      case (i_reg_addr)
        `SARX_OFF_CH3: sec_rx_ch3_route_sel <= i_reg_wdata & `SARX_WMASK_CH34;
        `SARX_OFF_CH4: sec_rx_ch4_route_sel <= i_reg_wdata & `SARX_WMASK_CH34;
        `SARX_OFF_CH5: sec_rx_ch5_route_sel <= i_reg_wdata & `SARX_WMASK_CH5;
        default: ;
      endcase
    end
  end

  // register reads, answered one cycle later; unmapped reads zero
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
      o_reg_rdata <= 8'h00;
    else if (i_reg_rd)
    begin
      case (i_reg_addr)
        `SARX_OFF_CH3: o_reg_rdata <= sec_rx_ch3_route_sel;
        `SARX_OFF_CH4: o_reg_rdata <= sec_rx_ch4_route_sel;
        `SARX_OFF_CH5: o_reg_rdata <= sec_rx_ch5_route_sel;
        default:       o_reg_rdata <= 8'h00;
      endcase
    end
  end

  // channel 3 destination
  always_ff @(posedge i_mclk)
  begin
    if (i_rst || !ch3_en)
    begin
      o_dac3_data  <= '0;
      o_dac3_valid <= 1'b0;
    end
    else
    begin
      o_dac3_valid <= hit3;
      if (hit3)
        o_dac3_data <= i_slot_data;
    end
  end

  // channel 4 destination
  always_ff @(posedge i_mclk)
  begin
    if (i_rst || !ch4_en)
    begin
      o_dac4_data  <= '0;
      o_dac4_valid <= 1'b0;
    end
    else
    begin
      o_dac4_valid <= hit4;
      if (hit4)
        o_dac4_data <= i_slot_data;
    end
  end

  // channel 5 destinations; the unselected one and reserved route stay at zero
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      o_dac5_data     <= '0;
      o_dac5_valid    <= 1'b0;
      o_adc1_lb_data  <= '0;
      o_adc1_lb_valid <= 1'b0;
    end
    else
    begin
      case (ch5_route)
        SARX_C5_DAC:
        begin
          o_dac5_valid    <= hit5;
          o_adc1_lb_data  <= '0;
          o_adc1_lb_valid <= 1'b0;
          if (hit5)
            o_dac5_data <= i_slot_data;
        end
        SARX_C5_LOOP:
        begin
          o_adc1_lb_valid <= hit5;
          o_dac5_data     <= '0;
          o_dac5_valid    <= 1'b0;
          if (hit5)
            o_adc1_lb_data <= i_slot_data;
        end
        default:
        begin
          o_dac5_data     <= '0;
          o_dac5_valid    <= 1'b0;
          o_adc1_lb_data  <= '0;
          o_adc1_lb_valid <= 1'b0;
        end
      endcase
    end
  end

  rsvd_ch34_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_reg_rd && (i_reg_addr == `SARX_OFF_CH3 || i_reg_addr == `SARX_OFF_CH4))
    |=> (o_reg_rdata[7:6] == 2'b00))
    else $error("reserved bits of channel 3 or 4 read nonzero");

  rsvd_ch5_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_reg_rd && i_reg_addr == `SARX_OFF_CH5) |=> (o_reg_rdata[7] == 1'b0))
    else $error("reserved bit of channel 5 read nonzero");

  ch3_route_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (ch3_en && i_fmt_tdm && i_slot_valid && i_slot_num == sec_rx_ch3_slot_index
     && !(i_reg_wr && i_reg_addr == `SARX_OFF_CH3))
    |=> (o_dac3_valid && o_dac3_data == $past(i_slot_data)))
    else $error("selected tdm slot not routed to dac channel 3");

  slot_side_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (ch3_en && !i_fmt_tdm && i_slot_valid && i_slot_num[4] == 1'b0
     && i_slot_right == sec_rx_ch3_slot_index[4]
     && i_slot_num[3:0] == sec_rx_ch3_slot_index[3:0]
     && !(i_reg_wr && i_reg_addr == `SARX_OFF_CH3))
    |=> o_dac3_valid)
    else $error("left/right slot not captured for channel 3");

  slot_miss_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_fmt_tdm && i_slot_valid && i_slot_num != sec_rx_ch4_slot_index)
    |=> !o_dac4_valid)
    else $error("channel 4 captured a wrong slot");

  reset_vals_a: assert property (@(posedge i_mclk)
    $past(i_rst) |-> (sec_rx_ch3_route_sel == `SARX_RST_CH3
     && sec_rx_ch4_route_sel == `SARX_RST_CH4 && sec_rx_ch5_route_sel == `SARX_RST_CH5))
    else $error("routing registers wrong after reset");

  ch4_route_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (ch4_en && i_slot_valid && !(i_reg_wr && i_reg_addr == `SARX_OFF_CH4)
     && (i_fmt_tdm ? (i_slot_num == sec_rx_ch4_slot_index)
         : (!i_slot_num[4] && i_slot_right == sec_rx_ch4_slot_index[4]
            && i_slot_num[3:0] == sec_rx_ch4_slot_index[3:0])))
    |=> (o_dac4_valid && o_dac4_data == $past(i_slot_data)))
    else $error("selected slot not routed to dac channel 4");

  ch4_wr_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_reg_wr && i_reg_addr == `SARX_OFF_CH4) ##1 (i_reg_rd && i_reg_addr == `SARX_OFF_CH4)
    |=> (o_reg_rdata == ($past(i_reg_wdata, 2) & 8'h3f)))
    else $error("channel 4 register readback mismatch");

  ch5_loop_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (ch5_route == SARX_C5_LOOP && i_slot_valid && !(i_reg_wr && i_reg_addr == `SARX_OFF_CH5)
     && (i_fmt_tdm ? (i_slot_num == sec_rx_ch5_slot_index)
         : (!i_slot_num[4] && i_slot_right == sec_rx_ch5_slot_index[4]
            && i_slot_num[3:0] == sec_rx_ch5_slot_index[3:0])))
    |=> (o_adc1_lb_valid && !o_dac5_valid && o_adc1_lb_data == $past(i_slot_data)))
    else $error("channel 5 loopback routing wrong");

  ch5_wr_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_reg_wr && i_reg_addr == `SARX_OFF_CH5) |=> (sec_rx_ch5_route_sel[7] == 1'b0
     && sec_rx_ch5_route_sel[6:0] == $past(i_reg_wdata[6:0])))
    else $error("channel 5 register write wrong");

  dis_zero_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (!ch3_en && !(i_reg_wr && i_reg_addr == `SARX_OFF_CH3))[*2]
    |-> (o_dac3_data == '0 && !o_dac3_valid))
    else $error("disabled channel 3 output not held at zero");

  dis5_zero_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (ch5_route == SARX_C5_OFF || ch5_route == SARX_C5_RSVD) ##1 1'b1
    |-> (o_dac5_data == '0 && o_adc1_lb_data == '0 && !o_dac5_valid && !o_adc1_lb_valid))
    else $error("disabled channel 5 outputs not zero");

  ch3_wr_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_reg_wr && i_reg_addr == `SARX_OFF_CH3)
    |=> (sec_rx_ch3_route_sel == ($past(i_reg_wdata) & 8'h3f)))
    else $error("channel 3 register write wrong");

  ch3_miss_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_fmt_tdm && i_slot_valid && i_slot_num != sec_rx_ch3_slot_index)
    |=> !o_dac3_valid)
    else $error("channel 3 captured a wrong slot");

  ch5_miss_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_fmt_tdm && i_slot_valid && i_slot_num != sec_rx_ch5_slot_index)
    |=> (!o_dac5_valid && !o_adc1_lb_valid))
    else $error("channel 5 captured a wrong slot");

  // left/right numbering only knows slots 0 to 15 on each side
  side_range_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (!i_fmt_tdm && i_slot_valid && i_slot_num[4])
    |=> (!o_dac3_valid && !o_dac4_valid && !o_dac5_valid && !o_adc1_lb_valid))
    else $error("out of range left/right slot captured");

  no_slot_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    !i_slot_valid
    |=> (!o_dac3_valid && !o_dac4_valid && !o_dac5_valid && !o_adc1_lb_valid))
    else $error("capture pulse without a slot word");

  ch3_hold_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (ch3_en && !i_slot_valid && !(i_reg_wr && i_reg_addr == `SARX_OFF_CH3))
    |=> $stable(o_dac3_data))
    else $error("channel 3 data changed without a capture");

  ch4_hold_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (ch4_en && !i_slot_valid && !(i_reg_wr && i_reg_addr == `SARX_OFF_CH4))
    |=> $stable(o_dac4_data))
    else $error("channel 4 data changed without a capture");

  ch5_dac_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (ch5_route == SARX_C5_DAC && i_fmt_tdm && i_slot_valid
     && i_slot_num == sec_rx_ch5_slot_index && !(i_reg_wr && i_reg_addr == `SARX_OFF_CH5))
    |=> (o_dac5_valid && !o_adc1_lb_valid && o_dac5_data == $past(i_slot_data)))
    else $error("channel 5 dac routing wrong");

  dis4_zero_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    !ch4_en ##1 1'b1
    |-> (o_dac4_data == '0 && !o_dac4_valid))
    else $error("disabled channel 4 output not held at zero");
endmodule

// ===== hdl/sarx_params.svh
// constants for the secondary receive slot map, channels 3 to 5
`ifndef SARX_PARAMS_SVH
`define SARX_PARAMS_SVH
`define SARX_OFF_CH3      8'h2a
`define SARX_OFF_CH4      8'h2b
`define SARX_OFF_CH5      8'h2c
`define SARX_RST_CH3      8'h02
`define SARX_RST_CH4      8'h03
`define SARX_RST_CH5      8'h04
`define SARX_WMASK_CH34   8'h3f
`define SARX_WMASK_CH5    8'h7f
`define SARX_EN_BIT       5
`define SARX_ROUTE_MSB    6
`define SARX_ROUTE_LSB    5
`define SARX_SLOT_MSB     4
`define SARX_SIDE_BIT     4
`define SARX_DATA_W       32
`endif

// ===== hdl/sarx_pkg.sv
// types for the secondary receive slot map
`include "sarx_params.svh"
package sarx_pkg;
  typedef logic [7:0]                 sarx_reg_t;
  typedef logic [4:0]                 sarx_slot_t;
  typedef logic [`SARX_DATA_W-1:0]    sarx_data_t;
  typedef enum logic [1:0]
  {
    SARX_C5_OFF,
    SARX_C5_DAC,
    SARX_C5_LOOP,
    SARX_C5_RSVD
  } sarx_route5_e;
endpackage

// ===== test/sarx_slot_src.sv
// slot word source standing in for the far-side serial host
`timescale 1ns/1ps
module sarx_slot_src
(
  input  wire logic        i_mclk,
  output      logic        o_fmt_tdm,
  output      logic        o_valid,
  output      logic [4:0]  o_num,
  output      logic        o_right,
  output      logic [31:0] o_data
);
  initial
  begin
    o_fmt_tdm = 1'b1;
    o_valid = 1'b0;
    o_num = 5'h0;
    o_right = 1'b0;
    o_data = 32'h0;
  end

  // one slot word, one cycle
  task automatic send(input logic f, input logic [4:0] n, input logic r, input logic [31:0] d);
    @(posedge i_mclk);
    o_fmt_tdm <= f;
    o_valid <= 1'b1;
    o_num <= n;
    o_right <= r;
    o_data <= d;
    @(posedge i_mclk);
    o_valid <= 1'b0;
    // lines scrambled once the word is gone
    o_num <= ~n;
    o_right <= ~r;
    o_data <= ~d;
  endtask
endmodule

// ===== test/sarx_slot_map_tb.sv
// self-checking bench for the secondary receive slot map
`timescale 1ns/1ps
module sarx_slot_map_tb;
  logic        i_mclk;
  logic        i_rst;
  logic [7:0]  addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic        wr;
  logic        rd;
  logic        rd_s;
  logic        fmt;
  logic        sv;
  logic        sr;
  logic [4:0]  sn;
  logic [4:0]  n;
  logic [31:0] sd;
  logic [31:0] s;
  logic [31:0] d3;
  logic [31:0] d4;
  logic [31:0] d5;
  logic [31:0] dl;
  logic        v3;
  logic        v4;
  logic        v5;
  logic        vl;
  int          error_cnt;
  int          checked;
  logic [39:0] expq[$];

  sarx_slot_map sarx_slot_map_inst (.i_mclk(i_mclk), .i_rst(i_rst), .i_reg_addr(addr),
    .i_reg_wr(wr), .i_reg_wdata(wdata), .i_reg_rd(rd), .o_reg_rdata(rdata),
    .i_fmt_tdm(fmt), .i_slot_valid(sv), .i_slot_num(sn), .i_slot_right(sr),
    .i_slot_data(sd), .o_dac3_data(d3), .o_dac3_valid(v3), .o_dac4_data(d4),
    .o_dac4_valid(v4), .o_dac5_data(d5), .o_dac5_valid(v5), .o_adc1_lb_data(dl),
    .o_adc1_lb_valid(vl));
  sarx_slot_src sarx_slot_src_inst (.i_mclk(i_mclk), .o_fmt_tdm(fmt), .o_valid(sv),
    .o_num(sn), .o_right(sr), .o_data(sd));

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task automatic final_report;
    if (expq.size() != 0)
      error_cnt++;
    $display("checked %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic take(input logic [7:0] id, input logic [31:0] got);
    logic [39:0] e;
    e = {8'hff, 32'h0};
    if (expq.size() != 0)
      e = expq.pop_front();
    checked++;
    if (e !== {id, got})
    begin
      error_cnt++;
      $display("BAD out%0h exp %h seen %h", id, e[31:0], got);
    end
  endtask

  task automatic wrr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge i_mclk);
    wr <= 1'b0;
  endtask

  task automatic rdr(input logic [7:0] a, input logic [7:0] e);
    expq.push_back({8'h8, 24'h0, e});
    @(posedge i_mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge i_mclk);
    rd <= 1'b0;
  endtask

  // write, then read back on the very next cycle
  task automatic wrd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
    expq.push_back({8'h8, 24'h0, e});
    @(posedge i_mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge i_mclk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge i_mclk);
    rd <= 1'b0;
  endtask

  // id 0: no capture expected
  task automatic slt(input logic f, input logic [4:0] k, input logic r, input logic [7:0] id);
    s = lfsr(s);
    if (id != 8'h0)
      expq.push_back({id, s});
    sarx_slot_src_inst.send(f, k, r, s);
  endtask

  task automatic zro(input logic [7:0] id);
    @(posedge i_mclk);
    #2;
    expq.push_back({id, 32'h0});
    take(id, id == 8'h3 ? d3 : id == 8'h4 ? d4 : id == 8'h5 ? d5 : dl);
  endtask

  // results watcher
  always @(posedge i_mclk)
  begin
    rd_s = rd;
    #1;
    if (rd_s === 1'b1) take(8'h8, {24'h0, rdata});
    if (v3 !== 1'b0) take(8'h3, d3);
    if (v4 !== 1'b0) take(8'h4, d4);
    if (v5 !== 1'b0) take(8'h5, d5);
    if (vl !== 1'b0) take(8'h1, dl);
  end

  initial
  begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end

  initial
  begin
    repeat (3000) @(posedge i_mclk);
    error_cnt++;
    final_report();
  end

  initial
  begin
    i_rst = 1'b1;
    addr = 8'h0;
    wdata = 8'h0;
    wr = 1'b0;
    rd = 1'b0;
    s = 32'h7288;
    error_cnt = 0;
    checked = 0;
    repeat (8) @(posedge i_mclk);
    i_rst <= 1'b0;
    rdr(8'h2a, 8'h02);
    rdr(8'h2b, 8'h03);
    rdr(8'h2c, 8'h04);
    rdr(8'h2d, 8'h00);
    $display("test reset values done");
    wrr(8'h2a, 8'h3f);
    wrr(8'h2b, 8'h3f);
    wrr(8'h2c, 8'h7f);
    rdr(8'h2a, 8'h3f);
    rdr(8'h2b, 8'h3f);
    rdr(8'h2c, 8'h7f);
    $display("test reserved bits done");
    for (int i = 0; i < 4; i++)
    begin
      n = s[4:0];
      wrr(8'h2a, {3'b001, n});
      wrr(8'h2b, {3'b001, n ^ 5'h1});
      wrr(8'h2c, {3'b001, n ^ 5'h2});
      slt(1'b1, n, 1'b0, 8'h3);
      slt(1'b1, n ^ 5'h1, 1'b1, 8'h4);
      slt(1'b1, n ^ 5'h2, 1'b0, 8'h5);
      slt(1'b1, n ^ 5'h3, 1'b0, 8'h0);
    end
    $display("test tdm routing done");
    wrr(8'h2a, 8'h33);
    wrr(8'h2b, 8'h03);
    wrr(8'h2c, 8'h44);
    slt(1'b0, 5'h3, 1'b1, 8'h3);
    slt(1'b0, 5'h3, 1'b0, 8'h0);
    slt(1'b0, 5'h13, 1'b1, 8'h0);
    slt(1'b0, 5'h4, 1'b0, 8'h1);
    $display("test i2s and loopback done");
    wrr(8'h2c, 8'h64);
    slt(1'b0, 5'h4, 1'b0, 8'h0);
    zro(8'h5);
    zro(8'h1);
    rdr(8'h2c, 8'h64);
    wrr(8'h2a, 8'h13);
    slt(1'b0, 5'h3, 1'b1, 8'h0);
    zro(8'h3);
    zro(8'h4);
    $display("test disable done");
    wrd(8'h2b, 8'h25, 8'h25);
    slt(1'b1, 5'h5, 1'b0, 8'h4);
    wrd(8'h2c, 8'h04, 8'h04);
    slt(1'b1, 5'h4, 1'b0, 8'h0);
    zro(8'h5);
    zro(8'h1);
    $display("test back to back and route off done");
    @(posedge i_mclk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_mclk);
    i_rst <= 1'b0;
    rdr(8'h2a, 8'h02);
    rdr(8'h2b, 8'h03);
    rdr(8'h2c, 8'h04);
    $display("test mid-run reset done");
    repeat (2) @(posedge i_mclk);
    final_report();
  end
endmodule
